// ===== hdl/cfgfb_pkg.sv
// Package: addresses, field positions, reset values and carriers of the config fuse bank
package cfgfb_pkg;

  // ==========================================================================
  // Byte addresses on the programming port
  // ==========================================================================
  localparam int          ADDR_W            = 22;
  localparam int          NUM_CFG           = 12;
  localparam logic [21:0] ADDR_OSC_CFG_HI   = 22'h300001;
  localparam logic [21:0] ADDR_POWER_CFG_LO = 22'h300002;
  localparam logic [21:0] ADDR_WDT_CFG_HI   = 22'h300003;
  localparam logic [21:0] ADDR_PMODE_CFG_LO = 22'h300004;
  localparam logic [21:0] ADDR_PINMUX_HI    = 22'h300005;
  localparam logic [21:0] ADDR_DBGPROG_LO   = 22'h300006;
  localparam logic [21:0] ADDR_CP_BLOCKS    = 22'h300008;
  localparam logic [21:0] ADDR_CP_BOOT_EE   = 22'h300009;
  localparam logic [21:0] ADDR_WP_BLOCKS    = 22'h30000A;
  localparam logic [21:0] ADDR_WP_SPECIAL   = 22'h30000B;
  localparam logic [21:0] ADDR_RP_BLOCKS    = 22'h30000C;
  localparam logic [21:0] ADDR_RP_BOOT      = 22'h30000D;
  localparam logic [21:0] ADDR_PART_ID_LO   = 22'h3FFFFE;
  localparam logic [21:0] ADDR_PART_ID_HI   = 22'h3FFFFF;

  // ==========================================================================
  // Storage indices, one per config byte
  // ==========================================================================
  localparam logic [3:0] IDX_OSC     = 4'h0;
  localparam logic [3:0] IDX_POWER   = 4'h1;
  localparam logic [3:0] IDX_WDT     = 4'h2;
  localparam logic [3:0] IDX_PMODE   = 4'h3;
  localparam logic [3:0] IDX_PINMUX  = 4'h4;
  localparam logic [3:0] IDX_DBGPROG = 4'h5;
  localparam logic [3:0] IDX_CP_BLK  = 4'h6;
  localparam logic [3:0] IDX_CP_BEE  = 4'h7;
  localparam logic [3:0] IDX_WP_BLK  = 4'h8;
  localparam logic [3:0] IDX_WP_SPC  = 4'h9;
  localparam logic [3:0] IDX_RP_BLK  = 4'hA;
  localparam logic [3:0] IDX_RP_BOOT = 4'hB;

  // Unprogrammed values, index 0 on the right
  localparam logic [NUM_CFG-1:0][7:0] CFG_RESET = {
    8'h40, 8'hFF, 8'hE0, 8'hFF, 8'hC0, 8'hFF,
    8'h85, 8'h01, 8'h83, 8'h0F, 8'h0F, 8'h27};
  // Implemented bit positions; the rest store and read zero
  localparam logic [NUM_CFG-1:0][7:0] CFG_IMPL = {
    8'h40, 8'hFF, 8'hE0, 8'hFF, 8'hC0, 8'hFF,
    8'h85, 8'h03, 8'h83, 8'h0F, 8'h0F, 8'h27};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_LOWPWR_SYSCLK = 5;
  localparam int LSB_OSC_SELECT    = 0;
  localparam int LSB_BOR_THRESH    = 2;
  localparam int BIT_BOR_EN        = 1;
  localparam int BIT_PWRT_EN_N     = 0;
  localparam int LSB_WDT_POST      = 1;
  localparam int BIT_WDT_FORCE     = 0;
  localparam int BIT_EXT_WAIT      = 7;
  localparam int LSB_PMODE         = 0;
  localparam int BIT_TMR_OSC_MUX   = 1;
  localparam int BIT_CCP2_MUX      = 0;
  localparam int BIT_DEBUG_N       = 7;
  localparam int BIT_LV_PROG       = 2;
  localparam int BIT_STACK_RST     = 0;
  localparam int BIT_EE_CP         = 7;
  localparam int BIT_BOOT_CP       = 6;
  localparam int BIT_EE_WP         = 7;
  localparam int BIT_BOOT_WP       = 6;
  localparam int BIT_CFG_WP        = 5;
  localparam int BIT_BOOT_RP       = 6;
  localparam int LSB_PART_LO       = 5;

  // ==========================================================================
  // Encodings and brown-out trip levels
  // ==========================================================================
  localparam logic [2:0]  OSC_RC_PORT  = 3'b111;
  localparam logic [2:0]  OSC_HS_PLL   = 3'b110;
  localparam logic [2:0]  OSC_EC_PORT  = 3'b101;
  localparam logic [2:0]  OSC_RC_DIV4  = 3'b100;
  localparam logic [1:0]  PM_MICROCTL  = 2'b11;
  localparam logic [1:0]  PM_MICROPROC = 2'b10;
  localparam logic [1:0]  PM_MP_BOOT   = 2'b01;
  localparam logic [1:0]  PM_EXT_MCU   = 2'b00;
  localparam logic [12:0] BOR_MV_2V0   = 13'd2000;
  localparam logic [12:0] BOR_MV_2V7   = 13'd2700;
  localparam logic [12:0] BOR_MV_4V2   = 13'd4200;
  localparam logic [12:0] BOR_MV_4V5   = 13'd4500;

  typedef enum logic [1:0] {MODE_RUN, MODE_LV_PROG, MODE_HV_PROG} cfgfb_mode_e;

  // Byte request from the serial programming engine
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } cfgfb_prog_req_s;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
    logic       wack;
    logic       werr;
  } cfgfb_prog_rsp_s;

  // Decoded settings handed to the core
  typedef struct packed {
    logic [2:0]  osc_select;
    logic        osc_pll_en;
    logic        osc_pin_is_port;
    logic        osc_div4_out;
    logic        lowpwr_sysclk_en;
    logic        brownout_enable;
    logic [1:0]  brownout_threshold;
    logic [12:0] brownout_mv;
    logic        powerup_timer_en;
    logic [2:0]  watchdog_postscale;
    logic [7:0]  watchdog_ratio;
    logic        watchdog_force_on;
    logic        ext_bus_wait_off;
    logic [1:0]  processor_mode_select;
    logic        timer_osc_legacy;
    logic        ccp2_on_port_c;
    logic        debugger_en;
    logic        stack_fault_reset_enable;
    logic [7:0]  block_code_protect;
    logic        boot_code_protect;
    logic        eeprom_code_protect;
    logic [7:0]  block_write_protect;
    logic        boot_write_protect;
    logic        eeprom_write_protect;
    logic        config_write_protect;
    logic [7:0]  block_table_read_protect;
    logic        boot_table_read_protect;
  } cfgfb_core_cfg_s;

endpackage

// ===== hdl/cfgfb_top.sv
// Config fuse bank: byte store, part identity, programming entry and decoded settings
`timescale 1ns/1ps
`default_nettype none

module cfgfb_top
  import cfgfb_pkg::*;
#(
  parameter int unsigned PART_NUMBER = 32'd1365, // Arbitrary value
  parameter int unsigned REVISION    = 32'd3     // Arbitrary value
) (
  input  wire logic            SYS_CLK_I,
  input  wire logic            NRST_I,
  input  wire cfgfb_prog_req_s PROG_REQ_I,
  output var  cfgfb_prog_rsp_s PROG_RSP_O,
  input  wire logic            MCLR_HV_DETECT_I,
  input  wire logic            PROG_ENTRY_PIN_I,
  input  wire logic            WATCHDOG_SW_ENABLE_I,
  input  wire logic [1:0]      EXT_BUS_WAIT_STATES_I,
  output var  logic            LV_PROG_ACTIVE_O,
  output var  logic            HV_PROG_ACTIVE_O,
  output var  logic            PROG_ENTRY_GPIO_EN_O,
  output var  logic            WATCHDOG_ON_O,
  output var  logic [1:0]      EXT_BUS_WAIT_O,
  output var  cfgfb_core_cfg_s CORE_CFG_O
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (PART_NUMBER > 32'd2047) begin : g_bad_part
    $error("PART_NUMBER does not fit eleven bits");
  end
  if (REVISION > 32'd31) begin : g_bad_rev
    $error("REVISION does not fit five bits");
  end

  localparam logic [10:0] PART_NUM = PART_NUMBER[10:0];
  localparam logic [4:0]  REV_CODE = REVISION[4:0];

  // Identity bytes assembled once
  localparam logic [7:0] ID_LO = {PART_NUM[2:0], REV_CODE};
  localparam logic [7:0] ID_HI = PART_NUM[10:3];

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0]                hv_sync;
    logic [1:0]                pin_sync;
    cfgfb_mode_e               mode;
    logic [NUM_CFG-1:0][7:0]   cfg;
    logic                      sampled;
    cfgfb_core_cfg_s           core;
    cfgfb_prog_rsp_s           rsp;
    logic                      gpio_en;
    logic                      wdt_on;
    logic [1:0]                wait_st;
    logic                      lv_act;
    logic                      hv_act;
  } cfgfb_state_s;

  cfgfb_state_s st;
  cfgfb_state_s next_st;

  // ==========================================================================
  // Functions
  // ==========================================================================

  // Address to storage index; hit low when not a config byte
  function automatic logic [4:0] cfg_index(input logic [21:0] a);
    logic [4:0] r;
    r = 5'h00;
    unique case (a)
      ADDR_OSC_CFG_HI:   r = {1'b1, IDX_OSC};
      ADDR_POWER_CFG_LO: r = {1'b1, IDX_POWER};
      ADDR_WDT_CFG_HI:   r = {1'b1, IDX_WDT};
      ADDR_PMODE_CFG_LO: r = {1'b1, IDX_PMODE};
      ADDR_PINMUX_HI:    r = {1'b1, IDX_PINMUX};
      ADDR_DBGPROG_LO:   r = {1'b1, IDX_DBGPROG};
      ADDR_CP_BLOCKS:    r = {1'b1, IDX_CP_BLK};
      ADDR_CP_BOOT_EE:   r = {1'b1, IDX_CP_BEE};
      ADDR_WP_BLOCKS:    r = {1'b1, IDX_WP_BLK};
      ADDR_WP_SPECIAL:   r = {1'b1, IDX_WP_SPC};
      ADDR_RP_BLOCKS:    r = {1'b1, IDX_RP_BLK};
      ADDR_RP_BOOT:      r = {1'b1, IDX_RP_BOOT};
      default:           r = 5'h00;
    endcase
    return r;
  endfunction

  // Brown-out code to trip level in millivolts
  function automatic logic [12:0] bor_mv(input logic [1:0] code);
    logic [12:0] mv;
    mv = BOR_MV_4V5;
    unique case (code)
      2'b11: mv = BOR_MV_2V0;
      2'b10: mv = BOR_MV_2V7;
      2'b01: mv = BOR_MV_4V2;
      2'b00: mv = BOR_MV_4V5;
    endcase
    return mv;
  endfunction

  // Raw bytes to the settings the core consumes
  function automatic cfgfb_core_cfg_s decode(input logic [NUM_CFG-1:0][7:0] c);
    cfgfb_core_cfg_s d;
    logic [2:0]      osc;
    d   = '0;
    osc = c[IDX_OSC][LSB_OSC_SELECT +: 3];
    d.osc_select         = osc;
    d.osc_pll_en         = (osc == OSC_HS_PLL);
    d.osc_pin_is_port    = (osc == OSC_RC_PORT) || (osc == OSC_EC_PORT);
    d.osc_div4_out       = (osc == OSC_RC_DIV4);
    d.lowpwr_sysclk_en   = ~c[IDX_OSC][BIT_LOWPWR_SYSCLK];
    d.brownout_enable    = c[IDX_POWER][BIT_BOR_EN];
    d.brownout_threshold = c[IDX_POWER][LSB_BOR_THRESH +: 2];
    d.brownout_mv        = bor_mv(c[IDX_POWER][LSB_BOR_THRESH +: 2]);
    d.powerup_timer_en   = ~c[IDX_POWER][BIT_PWRT_EN_N];
    d.watchdog_postscale = c[IDX_WDT][LSB_WDT_POST +: 3];
    d.watchdog_ratio     = 8'h01 << c[IDX_WDT][LSB_WDT_POST +: 3];
    d.watchdog_force_on  = c[IDX_WDT][BIT_WDT_FORCE];
    d.ext_bus_wait_off   = c[IDX_PMODE][BIT_EXT_WAIT];
    d.processor_mode_select = c[IDX_PMODE][LSB_PMODE +: 2];
    d.timer_osc_legacy   = c[IDX_PINMUX][BIT_TMR_OSC_MUX];
    d.ccp2_on_port_c     = c[IDX_PINMUX][BIT_CCP2_MUX];
    d.debugger_en        = ~c[IDX_DBGPROG][BIT_DEBUG_N];
    d.stack_fault_reset_enable = c[IDX_DBGPROG][BIT_STACK_RST];
    // Protection outputs are active high: 1 means the region is guarded
    d.block_code_protect   = ~c[IDX_CP_BLK];
    d.boot_code_protect    = ~c[IDX_CP_BEE][BIT_BOOT_CP];
    d.eeprom_code_protect  = ~c[IDX_CP_BEE][BIT_EE_CP];
    d.block_write_protect  = ~c[IDX_WP_BLK];
    d.boot_write_protect   = ~c[IDX_WP_SPC][BIT_BOOT_WP];
    d.eeprom_write_protect = ~c[IDX_WP_SPC][BIT_EE_WP];
    d.config_write_protect = ~c[IDX_WP_SPC][BIT_CFG_WP];
    d.block_table_read_protect = ~c[IDX_RP_BLK];
    d.boot_table_read_protect  = ~c[IDX_RP_BOOT][BIT_BOOT_RP];
    return d;
  endfunction

  // Decoded factory image as a constant, so the async reset loads constants only
  localparam cfgfb_core_cfg_s CORE_RESET = decode(CFG_RESET);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic [4:0] rd_hit;
  logic [4:0] wr_hit;
  logic       lv_prog_en;
  logic       hv_seen;
  logic       pin_seen;
  logic       cfg_locked;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  always_comb begin
    next_st = st;

    // Pins cross in through two flops; only the second flop, bit 1, is read below
    next_st.hv_sync  = {st.hv_sync[0], MCLR_HV_DETECT_I};
    next_st.pin_sync = {st.pin_sync[0], PROG_ENTRY_PIN_I};
    hv_seen    = st.hv_sync[1];
    pin_seen   = st.pin_sync[1];
    lv_prog_en = st.cfg[IDX_DBGPROG][BIT_LV_PROG];
    cfg_locked = ~st.cfg[IDX_WP_SPC][BIT_CFG_WP];

    // Entry and exit of programming modes
    unique case (st.mode)
      MODE_RUN: begin
        if (hv_seen) begin
          next_st.mode = MODE_HV_PROG;
        end else if (pin_seen && lv_prog_en) begin
          next_st.mode = MODE_LV_PROG;
        end
      end
      MODE_LV_PROG: begin
        if (hv_seen) begin
          next_st.mode = MODE_HV_PROG;
        end else if (!pin_seen) begin
          next_st.mode = MODE_RUN;
        end
      end
      MODE_HV_PROG: begin
        if (!hv_seen) begin
          next_st.mode = MODE_RUN;
        end
      end
    endcase

    // Pin is I/O only with low-voltage entry disabled and not in that mode
    next_st.gpio_en = ~lv_prog_en && (next_st.mode != MODE_LV_PROG);
    // Mode flags kept in flops beside the mode, so the outputs need no decode
    next_st.lv_act = (next_st.mode == MODE_LV_PROG);
    next_st.hv_act = (next_st.mode == MODE_HV_PROG);

    // Byte read: one cycle later, masked, identity always visible
    rd_hit  = cfg_index(PROG_REQ_I.addr);
    rd_byte = 8'h00;
    if (rd_hit[4]) begin
      rd_byte = st.cfg[rd_hit[3:0]] & CFG_IMPL[rd_hit[3:0]];
    end else if (PROG_REQ_I.addr == ADDR_PART_ID_LO) begin
      rd_byte = ID_LO;
    end else if (PROG_REQ_I.addr == ADDR_PART_ID_HI) begin
      rd_byte = ID_HI;
    end
    next_st.rsp.rvalid = PROG_REQ_I.rd;
    next_st.rsp.rdata  = PROG_REQ_I.rd ? rd_byte : 8'h00;

    // Byte write: programming mode only, config unlocked, config bytes only
    wr_hit  = cfg_index(PROG_REQ_I.addr);
    wr_byte = PROG_REQ_I.wdata;
    next_st.rsp.wack = 1'b0;
    next_st.rsp.werr = 1'b0;
    if (PROG_REQ_I.wr) begin
      if (wr_hit[4] && (st.mode != MODE_RUN) && !cfg_locked) begin
        if ((wr_hit[3:0] == IDX_DBGPROG) && (st.mode != MODE_HV_PROG)) begin
          // Keep the entry enable unless under high voltage
          wr_byte[BIT_LV_PROG] = lv_prog_en;
        end
        next_st.cfg[wr_hit[3:0]] = wr_byte & CFG_IMPL[wr_hit[3:0]];
        next_st.rsp.wack = 1'b1;
      end else begin
        next_st.rsp.werr = 1'b1;
      end
    end

    // Core copy taken once after reset release, then frozen
    if (!st.sampled) begin
      next_st.core    = decode(st.cfg);
      next_st.sampled = 1'b1;
    end

    // Watchdog on when forced, else under software control
    next_st.wdt_on = st.core.watchdog_force_on | WATCHDOG_SW_ENABLE_I;
    // No wait states when the wait bit is set
    next_st.wait_st = st.core.ext_bus_wait_off ? 2'b00 : EXT_BUS_WAIT_STATES_I;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Bank restarts from unprogrammed values; a real fuse array would persist
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st          <= '0;
      st.mode     <= MODE_RUN;
      st.cfg      <= CFG_RESET;
      st.core     <= CORE_RESET;
      st.gpio_en  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  // ==========================================================================
  assign PROG_RSP_O           = st.rsp;
  assign LV_PROG_ACTIVE_O     = st.lv_act;
  assign HV_PROG_ACTIVE_O     = st.hv_act;
  assign PROG_ENTRY_GPIO_EN_O = st.gpio_en;
  assign WATCHDOG_ON_O        = st.wdt_on;
  assign EXT_BUS_WAIT_O       = st.wait_st;
  assign CORE_CFG_O           = st.core;

endmodule

`default_nettype wire

// ===== verif/cfgfb_monitor.sv
// Port checker of the config fuse bank
`timescale 1ns/1ps
`default_nettype none

module cfgfb_monitor
  import cfgfb_pkg::*;
#(
  parameter int unsigned PART_NUMBER = 32'h00000555,
  parameter int unsigned REVISION    = 32'h00000003
) (
  input wire logic            SYS_CLK_I,
  input wire logic            NRST_I,
  input wire cfgfb_prog_req_s PROG_REQ_I,
  input wire cfgfb_prog_rsp_s PROG_RSP_O,
  input wire logic            MCLR_HV_DETECT_I,
  input wire logic            WATCHDOG_SW_ENABLE_I,
  input wire logic            LV_PROG_ACTIVE_O,
  input wire logic            HV_PROG_ACTIVE_O,
  input wire logic            PROG_ENTRY_GPIO_EN_O,
  input wire logic            WATCHDOG_ON_O,
  input wire logic [1:0]      EXT_BUS_WAIT_O,
  input wire cfgfb_core_cfg_s CORE_CFG_O
);
  localparam logic [10:0] PN = PART_NUMBER[10:0];
  localparam logic [4:0]  RV = REVISION[4:0];

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  // Four samples cover the two sync flops plus the mode flop
  sequence hv_held_s;
    MCLR_HV_DETECT_I [*4];
  endsequence
  sequence id_lo_rd_s;
    PROG_REQ_I.rd && PROG_REQ_I.addr == ADDR_PART_ID_LO;
  endsequence
  sequence id_hi_rd_s;
    PROG_REQ_I.rd && PROG_REQ_I.addr == ADDR_PART_ID_HI;
  endsequence

  // ==========================================================================
  // Programming port
  // ==========================================================================
  read_answer_a: assert property (PROG_REQ_I.rd |=> PROG_RSP_O.rvalid)
    else $error("read not answered one cycle later");
  stray_valid_a: assert property (!PROG_REQ_I.rd |=> !PROG_RSP_O.rvalid)
    else $error("read valid without a read");
  write_answer_a: assert property (PROG_REQ_I.wr |=> PROG_RSP_O.wack != PROG_RSP_O.werr)
    else $error("write not answered by exactly one of ack or error");
  run_refuse_a: assert property ((PROG_REQ_I.wr && !HV_PROG_ACTIVE_O && !LV_PROG_ACTIVE_O)
    |=> PROG_RSP_O.werr)
    else $error("write accepted outside programming mode");
  part_low_a: assert property (id_lo_rd_s |=> PROG_RSP_O.rdata == {PN[2:0], RV})
    else $error("low identity byte wrong");
  part_high_a: assert property (id_hi_rd_s |=> PROG_RSP_O.rdata == PN[10:3])
    else $error("high identity byte wrong");

  // ==========================================================================
  // Pins and decoded settings
  // ==========================================================================
  gpio_excl_a: assert property (PROG_ENTRY_GPIO_EN_O |-> !LV_PROG_ACTIVE_O)
    else $error("entry pin released while in low-voltage mode");
  hv_entry_a: assert property (hv_held_s |-> HV_PROG_ACTIVE_O)
    else $error("high voltage held but mode not entered");
  wdog_on_a: assert property ((CORE_CFG_O.watchdog_force_on || WATCHDOG_SW_ENABLE_I)
    |=> WATCHDOG_ON_O)
    else $error("watchdog not on");
  wait_off_a: assert property (CORE_CFG_O.ext_bus_wait_off |=> EXT_BUS_WAIT_O == 2'b00)
    else $error("wait states given while unavailable");
  cfg_frozen_a: assert property ($past(NRST_I) |-> $stable(CORE_CFG_O))
    else $error("core settings changed without reset");
endmodule

bind cfgfb_top cfgfb_monitor #(
  .PART_NUMBER(PART_NUMBER),
  .REVISION   (REVISION)
) cfgfb_monitor_i (
  .SYS_CLK_I           (SYS_CLK_I),
  .NRST_I              (NRST_I),
  .PROG_REQ_I          (PROG_REQ_I),
  .PROG_RSP_O          (PROG_RSP_O),
  .MCLR_HV_DETECT_I    (MCLR_HV_DETECT_I),
  .WATCHDOG_SW_ENABLE_I(WATCHDOG_SW_ENABLE_I),
  .LV_PROG_ACTIVE_O    (LV_PROG_ACTIVE_O),
  .HV_PROG_ACTIVE_O    (HV_PROG_ACTIVE_O),
  .PROG_ENTRY_GPIO_EN_O(PROG_ENTRY_GPIO_EN_O),
  .WATCHDOG_ON_O       (WATCHDOG_ON_O),
  .EXT_BUS_WAIT_O      (EXT_BUS_WAIT_O),
  .CORE_CFG_O          (CORE_CFG_O)
);

`default_nettype wire

// ===== verif/cfgfb_prog_model.sv
// Behavioural external programmer on the byte port and entry pins
`timescale 1ns/1ps
`default_nettype none

module cfgfb_prog_model
  import cfgfb_pkg::*;
(
  input  wire logic            clk_i,
  input  wire cfgfb_prog_rsp_s rsp_i,
  output var  cfgfb_prog_req_s req_o,
  output var  logic            mclr_hv_o,
  output var  logic            entry_pin_o
);
  cfgfb_prog_rsp_s last_rsp;

  // Idle port and pins at time zero
  initial begin
    req_o = '0;
    mclr_hv_o = 1'b0;
    entry_pin_o = 1'b0;
    last_rsp = '0;
  end

  // One byte per request; answer taken the cycle after the taking edge
  task automatic access(input logic rd, input logic wr, input logic [21:0] addr,
                        input logic [7:0] data);
    @(posedge clk_i);
    #1;
    req_o = '{rd: rd, wr: wr, addr: addr, wdata: data};
    @(posedge clk_i);
    #1;
    last_rsp = rsp_i;
    // Released lines carry junk so a stale byte never looks valid
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // Pin change, then wait out sync and mode latency; entry enable changes only under high voltage
  task automatic pins(input logic hv, input logic pin);
    @(posedge clk_i);
    #1;
    mclr_hv_o = hv;
    entry_pin_o = pin;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

// ===== verif/config_fuse_bank_test.sv
// Self-checking bench of the config fuse bank
`timescale 1ns/1ps
`default_nettype none

module config_fuse_bank_test;
  import cfgfb_pkg::*;

  typedef struct {
    logic [21:0] addr;
    logic [7:0]  data;
  } cfgfb_row_s;

  localparam logic [10:0] PNB = 11'h4D2; // Arbitrary value
  localparam logic [4:0]  RVB = 5'h11;   // Arbitrary value

  logic            sys_clk = 1'b0;
  logic            nrst;
  logic            sw_en;
  logic [1:0]      waits;
  cfgfb_prog_req_s req;
  cfgfb_prog_rsp_s rsp;
  logic            mclr_hv, entry_pin, lv_act, hv_act, gpio_en, wd_on;
  logic [1:0]      ext_wait;
  cfgfb_core_cfg_s core;
  int              err_total = 0;
  int              samples_checked = 0;

  // Factory image, unmapped holes and identity bytes
  cfgfb_row_s rows [16] = '{'{22'h300001, 8'h27}, '{22'h300002, 8'h0F},
    '{22'h300003, 8'h0F}, '{22'h300004, 8'h83}, '{22'h300005, 8'h01},
    '{22'h300006, 8'h85}, '{22'h300008, 8'hFF}, '{22'h300009, 8'hC0},
    '{22'h30000A, 8'hFF}, '{22'h30000B, 8'hE0}, '{22'h30000C, 8'hFF},
    '{22'h30000D, 8'h40}, '{22'h300007, 8'h00}, '{22'h300000, 8'h00},
    '{22'h3FFFFE, {PNB[2:0], RVB}}, '{22'h3FFFFF, PNB[10:3]}};

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %0t mismatch got %h expected %h", $time, (got), (exp)); end end

  always #5 sys_clk = ~sys_clk;

  cfgfb_top #(.PART_NUMBER(32'h000004D2), .REVISION(32'h00000011)) cfgfb_top_i (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst), .PROG_REQ_I(req), .PROG_RSP_O(rsp),
    .MCLR_HV_DETECT_I(mclr_hv), .PROG_ENTRY_PIN_I(entry_pin),
    .WATCHDOG_SW_ENABLE_I(sw_en), .EXT_BUS_WAIT_STATES_I(waits),
    .LV_PROG_ACTIVE_O(lv_act), .HV_PROG_ACTIVE_O(hv_act),
    .PROG_ENTRY_GPIO_EN_O(gpio_en), .WATCHDOG_ON_O(wd_on),
    .EXT_BUS_WAIT_O(ext_wait), .CORE_CFG_O(core));

  cfgfb_prog_model cfgfb_prog_model_i (.clk_i(sys_clk), .rsp_i(rsp), .req_o(req),
    .mclr_hv_o(mclr_hv), .entry_pin_o(entry_pin));

  task automatic wr_chk(input logic [21:0] a, input logic [7:0] d, input logic refused);
    cfgfb_prog_model_i.access(1'b0, 1'b1, a, d);
    `CHK(cfgfb_prog_model_i.last_rsp.werr, refused)
    `CHK(cfgfb_prog_model_i.last_rsp.wack, !refused)
  endtask

  task automatic rd_chk(input logic [21:0] a, input logic [7:0] exp);
    cfgfb_prog_model_i.access(1'b1, 1'b0, a, 8'h00);
    `CHK(cfgfb_prog_model_i.last_rsp.rvalid, 1'b1)
    `CHK(cfgfb_prog_model_i.last_rsp.rdata, exp)
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly ninety cycles the sequence needs
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    nrst = 1'b0;
    sw_en = 1'b1;
    waits = 2'b10;
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'b1;
    foreach (rows[i]) rd_chk(rows[i].addr, rows[i].data);
    `CHK(core.osc_select, 3'b111)
    `CHK(core.lowpwr_sysclk_en, 1'b0)
    `CHK(core.brownout_mv, 13'h07D0)
    `CHK(core.powerup_timer_en, 1'b0)
    `CHK(core.watchdog_ratio, 8'h80)
    `CHK(core.processor_mode_select, 2'b11)
    `CHK(core.ccp2_on_port_c, 1'b1)
    `CHK(core.debugger_en, 1'b0)
    `CHK(core.block_code_protect, 8'h00)
    `CHK(core.block_write_protect, 8'h00)
    `CHK(core.block_table_read_protect, 8'h00)
    `CHK(core.osc_pin_is_port, 1'b1)
    `CHK({core.osc_pll_en, core.osc_div4_out}, 2'b00)
    `CHK(core.brownout_enable, 1'b1)
    `CHK(core.watchdog_force_on, 1'b1)
    `CHK(core.ext_bus_wait_off, 1'b1)
    `CHK(core.timer_osc_legacy, 1'b0)
    `CHK(core.stack_fault_reset_enable, 1'b1)
    `CHK({core.boot_code_protect, core.eeprom_code_protect}, 2'b00)
    `CHK({core.boot_write_protect, core.eeprom_write_protect}, 2'b00)
    `CHK(core.boot_table_read_protect, 1'b0)
    sw_en = 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK(wd_on, 1'b1)
    `CHK(ext_wait, 2'b00)
    wr_chk(ADDR_DBGPROG_LO, 8'h81, 1'b1);
    // High voltage: masked write, identity refused, entry enable cleared
    cfgfb_prog_model_i.pins(1'b1, 1'b0);
    `CHK(hv_act, 1'b1)
    wr_chk(ADDR_DBGPROG_LO, 8'hFF, 1'b0);
    rd_chk(ADDR_DBGPROG_LO, 8'h85);
    wr_chk(ADDR_PART_ID_LO, 8'h00, 1'b1);
    wr_chk(ADDR_DBGPROG_LO, 8'h81, 1'b0);
    rd_chk(ADDR_DBGPROG_LO, 8'h81);
    // Run mode with entry enable clear: low-voltage entry refused, pin is plain I/O
    cfgfb_prog_model_i.pins(1'b0, 1'b1);
    `CHK(lv_act, 1'b0)
    `CHK(gpio_en, 1'b1)
    cfgfb_prog_model_i.pins(1'b1, 1'b1);
    `CHK(hv_act, 1'b1)
    // Protect written last, then config writes bounce
    wr_chk(ADDR_WP_SPECIAL, 8'hC0, 1'b0);
    wr_chk(ADDR_OSC_CFG_HI, 8'h07, 1'b1);
    rd_chk(ADDR_OSC_CFG_HI, 8'h27);
    rd_chk(ADDR_PART_ID_HI, PNB[10:3]);
    `CHK(core.config_write_protect, 1'b0)
    // Mid-run reset brings the factory image back
    cfgfb_prog_model_i.pins(1'b0, 1'b0);
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rd_chk(ADDR_DBGPROG_LO, 8'h85);
    cfgfb_prog_model_i.pins(1'b0, 1'b1);
    `CHK(lv_act, 1'b1)
    `CHK(gpio_en, 1'b0)
    wr_chk(ADDR_DBGPROG_LO, 8'h81, 1'b0);
    rd_chk(ADDR_DBGPROG_LO, 8'h85);
    finish_test();
  end
endmodule

`default_nettype wire
